// >>> design/sadc_defines.vh
// register offsets, field positions, reset values and timing counts of the converter sequencer
// assumes a 32-bit ahb-lite slave with one aligned word per register
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SADC_OFS_MUX 8'h00
`define SADC_OFS_CTLA 8'h04
`define SADC_OFS_CTLB 8'h08
`define SADC_OFS_RLOW 8'h0c
`define SADC_OFS_RHIGH 8'h10
`define SADC_OFS_DATA 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SADC_CTLA_PS_LO 0
`define SADC_CTLA_PS_HI 2
`define SADC_CTLA_FLAG 4
`define SADC_CTLA_ATE 5
`define SADC_CTLA_START 6
`define SADC_CTLA_EN 7
`define SADC_MUX_CH_LO 0
`define SADC_MUX_CH_HI 3
`define SADC_MUX_REFS2 4
`define SADC_MUX_LJ 5
`define SADC_MUX_REFS_LO 6
`define SADC_MUX_REFS_HI 7

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define SADC_RST_BYTE 8'h00
`define SADC_TEMP_CODE 4'hf
`define SADC_TS_FREE 3'h0

// ----------------------------------------------------------------
// timing in half converter clocks
// ----------------------------------------------------------------
`define SADC_HALF_NORMAL 6'd26
`define SADC_HALF_FIRST 6'd50
`define SADC_HALF_TRIG 6'd27
`define SADC_SAMPLE_NORMAL 6'd3
`define SADC_SAMPLE_FIRST 6'd27
`define SADC_SAMPLE_TRIG 6'd4

`endif

// >>> design/sadc_sync.v
// two-flop synchroniser for one asynchronous level
// assumes the input comes from outside the hclk domain

module sadc_sync
(
    input wire hclk,
    input wire hresetn,
    input wire d,
    output reg q
);

    reg meta;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end

endmodule // sadc_sync

// >>> design/sadc_sequencer.v
// sequencer of a 10-bit successive-approximation converter behind an ahb-lite slave
// assumes the analog core gives the result bits on sar_result once sar_sample is pulsed,
// and that trigger event inputs arrive asynchronously from other blocks
`include "sadc_defines.vh"

module sadc_sequencer
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [7:0] trig_events,
    input wire [9:0] sar_result,
    output reg conv_powered,
    output reg sar_sample,
    output reg sar_phase,
    output reg [3:0] channel_select,
    output reg [2:0] reference_select,
    output reg temp_sensor_sel,
    output reg diff_mode,
    output reg gain_20x
);

    // trigger event bit used for each trigger-select code; by default code n picks event bit n
    parameter [23:0] TRIG_MAP = 24'hfac688;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    reg [7:0] mux_control_reg;
    reg [7:0] conv_control_reg_b;
    reg conv_enable;
    reg conv_start;
    reg auto_trigger_en;
    reg conv_done_flag;
    reg [2:0] prescale_select;
    reg [7:0] result_high;
    reg [7:0] result_low;
    reg data_locked;
    reg wr_pend;
    reg rd_pend;
    reg [7:0] wr_addr;
    wire addr_ok;
    wire [7:0] ofs;
    wire [7:0] wbyte;
    wire wr_ctla;
    wire start_wr;

    assign ofs = haddr[7:0];
    assign addr_ok = hsel && hready && htrans[1];
    assign wbyte = hwdata[7:0];
    assign wr_ctla = wr_pend && (wr_addr == `SADC_OFS_CTLA);
    assign start_wr = wr_ctla && wbyte[`SADC_CTLA_START] && conv_enable;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            wr_pend <= addr_ok && hwrite;
            rd_pend <= addr_ok && !hwrite;
            if (addr_ok)
                wr_addr <= ofs;
        end
    end

    // read data registered in the address phase so hrdata comes straight from a flop
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (addr_ok && !hwrite)
        begin
            case (ofs)
                `SADC_OFS_MUX: hrdata <= {24'h000000, mux_control_reg};
                `SADC_OFS_CTLA: hrdata <= {24'h000000, conv_enable, conv_start, auto_trigger_en,
                    conv_done_flag, 1'b0, prescale_select};
                `SADC_OFS_CTLB: hrdata <= {24'h000000, conv_control_reg_b};
                `SADC_OFS_RLOW: hrdata <= {24'h000000, result_low};
                `SADC_OFS_RHIGH: hrdata <= {24'h000000, result_high};
                `SADC_OFS_DATA: hrdata <= {16'h0000, result_high, result_low};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    wire rd_low;
    wire rd_high;
    assign rd_low = addr_ok && !hwrite && (ofs == `SADC_OFS_RLOW);
    assign rd_high = addr_ok && !hwrite && ((ofs == `SADC_OFS_RHIGH) || (ofs == `SADC_OFS_DATA));

    // ------------------------------------------------------------
    // trigger path
    // ------------------------------------------------------------
    wire [7:0] trig_sync;
    reg trig_prev;
    reg busy;
    wire trig_sel;
    wire trig_rise;
    wire [2:0] ts;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_sync
            sadc_sync u_sync
            (
                .hclk(hclk),
                .hresetn(hresetn),
                .d(trig_events[gi]),
                .q(trig_sync[gi])
            );
        end
    endgenerate

    assign ts = conv_control_reg_b[2:0];
    assign trig_sel = trig_sync[TRIG_MAP[ts*3 +: 3]];

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            trig_prev <= 1'b0;
        else
            trig_prev <= trig_sel;
    end

    // level still high at end makes no new edge; edges while busy are dropped
    assign trig_rise = trig_sel && !trig_prev && auto_trigger_en && conv_enable && !busy
        && (ts != `SADC_TS_FREE);

    // ------------------------------------------------------------
    // prescaler: half-period enable of the converter clock
    // ------------------------------------------------------------
    reg [6:0] pre_cnt;
    reg half_tick;
    wire [6:0] pre_half;

    assign pre_half = (prescale_select == 3'd0) ? 7'd0 : (7'd64 >> (3'd7 - prescale_select)) - 7'd1;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pre_cnt <= 7'd0;
            half_tick <= 1'b0;
        end
        else if (!conv_enable || trig_rise)
        begin
            pre_cnt <= 7'd0;
            half_tick <= 1'b0;
        end
        else if (pre_cnt >= pre_half)
        begin
            pre_cnt <= 7'd0;
            half_tick <= 1'b1;
        end
        else
        begin
            pre_cnt <= pre_cnt + 7'd1;
            half_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_CONV = 3'b100;

    reg [2:0] state;
    reg [5:0] half_cnt;
    reg [5:0] half_len;
    reg [5:0] sample_at;
    reg first_conv;
    reg clk_phase;
    wire rise_edge;
    wire conv_end;
    wire free_run;

    assign rise_edge = half_tick && !clk_phase;
    assign conv_end = (state == ST_CONV) && half_tick && (half_cnt == half_len - 6'd1);
    assign free_run = auto_trigger_en && (ts == `SADC_TS_FREE);

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= ST_IDLE;
            half_cnt <= 6'd0;
            half_len <= `SADC_HALF_NORMAL;
            sample_at <= `SADC_SAMPLE_NORMAL;
            first_conv <= 1'b1;
            clk_phase <= 1'b0;
            busy <= 1'b0;
            conv_start <= 1'b0;
            conv_done_flag <= 1'b0;
            sar_sample <= 1'b0;
            sar_phase <= 1'b0;
            result_high <= `SADC_RST_BYTE;
            result_low <= `SADC_RST_BYTE;
            data_locked <= 1'b0;
        end
        else
        begin
            sar_sample <= 1'b0;
            if (rd_low)
                data_locked <= 1'b1;
            if (rd_high)
                data_locked <= 1'b0;
            if (!conv_enable || trig_rise)
                clk_phase <= 1'b0;
            else if (half_tick)
                clk_phase <= !clk_phase;
            sar_phase <= clk_phase && conv_enable;
            if (wr_ctla && wbyte[`SADC_CTLA_FLAG])
                conv_done_flag <= 1'b0;
            if (!conv_enable)
            begin
                state <= ST_IDLE;
                busy <= 1'b0;
                conv_start <= 1'b0;
                first_conv <= 1'b1;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        if (trig_rise)
                        begin
                            // triggered: conversion counted from the trigger edge
                            state <= ST_CONV;
                            busy <= 1'b1;
                            conv_start <= 1'b1;
                            half_cnt <= 6'd0;
                            half_len <= first_conv ? `SADC_HALF_FIRST : `SADC_HALF_TRIG;
                            sample_at <= first_conv ? `SADC_SAMPLE_FIRST : `SADC_SAMPLE_TRIG;
                        end
                        else if (start_wr)
                        begin
                            state <= ST_WAIT;
                            busy <= 1'b1;
                            conv_start <= 1'b1;
                        end
                    end
                    ST_WAIT:
                    begin
                        if (rise_edge)
                        begin
                            state <= ST_CONV;
                            half_cnt <= 6'd0;
                            half_len <= first_conv ? `SADC_HALF_FIRST : `SADC_HALF_NORMAL;
                            sample_at <= first_conv ? `SADC_SAMPLE_FIRST : `SADC_SAMPLE_NORMAL;
                        end
                    end
                    ST_CONV:
                    begin
                        if (half_tick)
                        begin
                            half_cnt <= half_cnt + 6'd1;
                            if (half_cnt == sample_at - 6'd1)
                                sar_sample <= 1'b1;
                        end
                        if (conv_end)
                        begin
                            first_conv <= 1'b0;
                            conv_done_flag <= 1'b1;
                            if (!data_locked && !rd_low)
                            begin
                                if (mux_control_reg[`SADC_MUX_LJ])
                                begin
                                    result_high <= sar_result[9:2];
                                    result_low <= {sar_result[1:0], 6'h00};
                                end
                                else
                                begin
                                    result_high <= {6'h00, sar_result[9:8]};
                                    result_low <= sar_result[7:0];
                                end
                            end
                            if (free_run)
                            begin
                                // next conversion starts at once; start bit stays set
                                state <= ST_CONV;
                                half_cnt <= 6'd0;
                                half_len <= `SADC_HALF_NORMAL;
                                sample_at <= `SADC_SAMPLE_NORMAL;
                            end
                            else
                            begin
                                state <= ST_IDLE;
                                busy <= 1'b0;
                                conv_start <= 1'b0;
                            end
                        end
                    end
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mux_control_reg <= `SADC_RST_BYTE;
            conv_control_reg_b <= `SADC_RST_BYTE;
            conv_enable <= 1'b0;
            auto_trigger_en <= 1'b0;
            prescale_select <= 3'd0;
        end
        else if (wr_pend)
        begin
            case (wr_addr)
                `SADC_OFS_MUX: mux_control_reg <= wbyte;
                `SADC_OFS_CTLB: conv_control_reg_b <= {5'h00, wbyte[2:0]};
                `SADC_OFS_CTLA:
                begin
                    conv_enable <= wbyte[`SADC_CTLA_EN];
                    auto_trigger_en <= wbyte[`SADC_CTLA_ATE];
                    prescale_select <= wbyte[`SADC_CTLA_PS_HI:`SADC_CTLA_PS_LO];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // applied selection: frozen while converting, tracks in the last cycle
    // ------------------------------------------------------------
    wire track;
    wire last_cycle;
    wire [3:0] ch_w;

    assign last_cycle = (state == ST_CONV) && (half_cnt >= half_len - 6'd2);
    assign track = !busy || (state == ST_WAIT && !rise_edge) || last_cycle;
    assign ch_w = mux_control_reg[`SADC_MUX_CH_HI:`SADC_MUX_CH_LO];

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            channel_select <= 4'h0;
            reference_select <= 3'h0;
            temp_sensor_sel <= 1'b0;
            diff_mode <= 1'b0;
            gain_20x <= 1'b0;
            conv_powered <= 1'b0;
        end
        else
        begin
            conv_powered <= conv_enable;
            if (!conv_enable)
            begin
                channel_select <= 4'h0;
                reference_select <= 3'h0;
                temp_sensor_sel <= 1'b0;
                diff_mode <= 1'b0;
                gain_20x <= 1'b0;
            end
            else if (track)
            begin
                channel_select <= ch_w;
                reference_select <= {mux_control_reg[`SADC_MUX_REFS2],
                    mux_control_reg[`SADC_MUX_REFS_HI:`SADC_MUX_REFS_LO]};
                temp_sensor_sel <= (ch_w == `SADC_TEMP_CODE);
                // codes 0-3 single ended, 4-13 differential with odd codes at 20x
                diff_mode <= (ch_w >= 4'h4) && (ch_w != `SADC_TEMP_CODE) && (ch_w != 4'he);
                gain_20x <= (ch_w >= 4'h4) && ch_w[0] && (ch_w != `SADC_TEMP_CODE);
            end
        end
    end

endmodule // sadc_sequencer

// >>> testbench/sadc_analog_model.sv
// sample-and-hold model of the analog core facing the sequencer
// assumes the bench sets level and the sequencer pulses sar_sample once per conversion
module sadc_analog_model (
    input logic hclk,
    input logic hresetn,
    input logic sar_sample,
    input logic [9:0] level,
    output logic [9:0] sar_result
);
    timeunit 1ns;
    timeprecision 1ns;
    // the held code only moves at a sample pulse, like a real hold capacitor
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            sar_result <= 10'h000;
        else if (sar_sample)
            sar_result <= level;
endmodule // sadc_analog_model

// >>> testbench/sadc_sequencer_assertions.sv
// concurrent checks on the converter sequencer outputs
// assumes one hclk domain with async active-low hresetn
module sadc_sequencer_checker (
    input logic hclk,
    input logic hresetn,
    input logic conv_powered,
    input logic sar_sample,
    input logic sar_phase,
    input logic [3:0] channel_select,
    input logic [2:0] reference_select,
    input logic temp_sensor_sel,
    input logic diff_mode,
    input logic gain_20x
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] still;
    logic ph_d;
    // cycles the converter clock has stood still while powered; slowest half period is 64
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            still <= 8'h00;
            ph_d <= 1'b0;
        end
        else
        begin
            ph_d <= sar_phase;
            still <= (!conv_powered || sar_phase != ph_d) ? 8'h00 : still + 8'h01;
        end
    property p_idle_quiet;
        !conv_powered [*2] |-> !sar_sample && !sar_phase && channel_select == 4'h0 && reference_select == 3'h0;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("converter active while disabled");
    property p_phase_runs;
        still <= 8'd130;
    endproperty
    a_phase_runs: assert property (p_phase_runs) else $error("converter clock stalled");
    property p_sample_spacing;
        sar_sample |=> !sar_sample [*8];
    endproperty
    a_sample_spacing: assert property (p_sample_spacing) else $error("sample pulses too close");
    property p_sample_powered;
        sar_sample |-> conv_powered && $past(conv_powered);
    endproperty
    a_sample_powered: assert property (p_sample_powered) else $error("sample while unpowered");
    property p_sel_frozen;
        sar_sample |=> ($stable(channel_select) && $stable(reference_select)) [*8];
    endproperty
    a_sel_frozen: assert property (p_sel_frozen) else $error("selection moved in conversion");
    property p_diff_decode;
        diff_mode == (channel_select >= 4'h4 && channel_select <= 4'hd);
    endproperty
    a_diff_decode: assert property (p_diff_decode) else $error("differential decode wrong");
    property p_gain_decode;
        gain_20x == (diff_mode && channel_select[0]);
    endproperty
    a_gain_decode: assert property (p_gain_decode) else $error("gain decode wrong");
    property p_temp_decode;
        temp_sensor_sel == (channel_select == 4'hf);
    endproperty
    a_temp_decode: assert property (p_temp_decode) else $error("temperature select wrong");
    c_sample: cover property (sar_sample);
    c_temp: cover property (temp_sensor_sel && sar_sample);
    c_gain: cover property (gain_20x && sar_sample);
endmodule // sadc_sequencer_checker

bind sadc_sequencer sadc_sequencer_checker u_sadc_sequencer_checker (.hclk(hclk), .hresetn(hresetn),
    .conv_powered(conv_powered), .sar_sample(sar_sample), .sar_phase(sar_phase), .channel_select(channel_select),
    .reference_select(reference_select), .temp_sensor_sel(temp_sensor_sel), .diff_mode(diff_mode),
    .gain_20x(gain_20x));

// >>> testbench/tb.sv
// self-checking bench of the converter sequencer: bus tasks, random and corner scenarios
// assumes the bench plays software and trigger sources, the model plays the analog core
`include "sadc_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] PS = 8'h06;
    localparam int CK = 64;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] htrans = 2'h0;
    logic [7:0] trig_events = 8'h00, mux_v = 8'h00, ctl = 8'h00;
    logic [9:0] sar_result, level = 10'h000;
    logic hreadyout, hresp, conv_powered, sar_sample, sar_phase, temp_sensor_sel, diff_mode, gain_20x;
    logic [3:0] channel_select;
    logic [2:0] reference_select;
    int err_total = 0, compares = 0, cyc = 0, nsamp = 0, last_s = 0, prev_s = 0, t0, dt;
    sadc_sequencer u_sadc_sequencer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .trig_events(trig_events), .sar_result(sar_result), .conv_powered(conv_powered),
        .sar_sample(sar_sample), .sar_phase(sar_phase), .channel_select(channel_select),
        .reference_select(reference_select), .temp_sensor_sel(temp_sensor_sel), .diff_mode(diff_mode),
        .gain_20x(gain_20x));
    sadc_analog_model u_sadc_analog_model (.hclk(hclk), .hresetn(hresetn), .sar_sample(sar_sample), .level(level),
        .sar_result(sar_result));
    initial
        forever #50 hclk = ~hclk;
    // ----
    // helpers
    // ----
    task wrap_up();
        $display("compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge hclk)
    begin
        cyc++;
        if (sar_sample === 1'b1)
        begin
            nsamp++;
            prev_s = last_s;
            last_s = cyc;
        end
        if (cyc == 40000)
        begin
            err_total++;
            wrap_up();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // start-to-event delays carry a little slack for prescaler phase and polling
    function logic inr(input int v, input int lo, input int hi);
        return v >= lo - 2 && v <= hi + 8;
    endfunction
    function logic [31:0] e_lo(input logic [9:0] v, input logic lj);
        return {24'h0, lj ? {v[1:0], 6'h00} : v[7:0]};
    endfunction
    function logic [31:0] e_hi(input logic [9:0] v, input logic lj);
        return {24'h0, lj ? v[9:2] : {6'h00, v[9:8]}};
    endfunction
    task res(input logic [9:0] v, input logic lj);
        bus(1'b0, `SADC_OFS_RLOW, 32'h0);
        chk(r, e_lo(v, lj));
        bus(1'b0, `SADC_OFS_RHIGH, 32'h0);
        chk(r, e_hi(v, lj));
    endtask
    task run(input logic first, input logic [9:0] v, input logic mid_en, input logic [7:0] mid);
        int n;
        n = 0;
        level <= v;
        bus(1'b1, `SADC_OFS_CTLA, {24'h0, ctl | 8'h50});
        t0 = cyc;
        bus(1'b0, `SADC_OFS_CTLA, 32'h0);
        chk(r[6], 1'b1);
        if (mid_en)
        begin
            repeat (2 * CK) @(posedge hclk);
            bus(1'b1, `SADC_OFS_MUX, {24'h0, mid});
            chk(channel_select, mux_v[3:0]);
        end
        chk(channel_select, mux_v[3:0]);
        chk(reference_select, {mux_v[4], mux_v[7:6]});
        while (r[6] === 1'b1 && n < 4000)
        begin
            bus(1'b0, `SADC_OFS_CTLA, 32'h0);
            n++;
        end
        dt = cyc - t0;
        chk(r[4], 1'b1);
        chk(inr(dt, first ? 25 * CK : 13 * CK, first ? 26 * CK : 14 * CK), 1'b1);
        chk(inr(last_s - t0, first ? 27 * CK / 2 : 3 * CK / 2, first ? 29 * CK / 2 : 5 * CK / 2), 1'b1);
        if (mid_en)
        begin
            repeat (4) @(posedge hclk);
            chk(channel_select, mid[3:0]);
            mux_v = mid;
        end
    endtask
    // ----
    // scenarios
    // ----
    initial
    begin
        logic [7:0] m;
        logic [9:0] v;
        int n0;
        r = $urandom(93);
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b1, 8'h20, 32'hff);
        bus(1'b1, `SADC_OFS_CTLA, 32'h40);
        for (int i = 0; i < 9; i++)
        begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk(r, 32'h0);
        end
        chk(sar_phase, 1'b0);
        chk({hreadyout, hresp, conv_powered}, 3'b100);
        // every prescale ratio: one full converter clock period in hclk cycles
        for (int p = 0; p < 8; p++)
        begin
            bus(1'b1, `SADC_OFS_CTLA, 32'h80 | p);
            repeat (2) @(posedge sar_phase);
            t0 = cyc;
            @(posedge sar_phase);
            chk(cyc - t0, p == 0 ? 2 : 1 << p);
        end
        $display("reset and refused writes done");
        ctl = 8'h80 | PS;
        bus(1'b1, `SADC_OFS_CTLA, {24'h0, ctl});
        run(1'b1, 10'h2a5, 1'b0, 8'h00);
        res(10'h2a5, 1'b0);
        run(1'b0, 10'h15a, 1'b0, 8'h00);
        res(10'h15a, 1'b0);
        bus(1'b0, `SADC_OFS_RLOW, 32'h0);
        run(1'b0, 10'h3ff, 1'b0, 8'h00);
        bus(1'b0, `SADC_OFS_RHIGH, 32'h0);
        chk(r, e_hi(10'h15a, 1'b0));
        run(1'b0, 10'h001, 1'b0, 8'h00);
        res(10'h001, 1'b0);
        $display("single conversions and lock done");
        for (int i = 0; i < 8; i++)
        begin
            m = 8'($urandom);
            v = 10'($urandom);
            if (i == 0)
                m[3:0] = 4'hf;
            m[4] = i[2];
            m[7:6] = i[1:0];
            bus(1'b1, `SADC_OFS_MUX, {24'h0, m});
            mux_v = m;
            run(1'b0, v, i == 3, {m[7:4], 4'h5});
            res(v, m[5]);
        end
        $display("random selections done");
        ctl = 8'ha0 | PS;
        for (int k = 1; k < 8; k++)
        begin
            bus(1'b1, `SADC_OFS_CTLB, 32'(k));
            bus(1'b1, `SADC_OFS_CTLA, {24'h0, ctl | 8'h10});
            n0 = nsamp;
            trig_events[k] <= 1'b1;
            t0 = cyc;
            repeat (CK) @(posedge hclk);
            bus(1'b0, `SADC_OFS_CTLA, 32'h0);
            chk(r[6], 1'b1);
            trig_events[k] <= 1'b0;
            @(posedge hclk);
            trig_events[k] <= 1'b1;
            repeat (20 * CK) @(posedge hclk);
            chk(nsamp - n0, 1);
            chk(inr(last_s - t0, 2 * CK + 3, 2 * CK + 3), 1'b1);
            bus(1'b0, `SADC_OFS_CTLA, 32'h0);
            chk(r[4], 1'b1);
            trig_events[k] <= 1'b0;
        end
        run(1'b0, 10'h0c3, 1'b0, 8'h00);
        res(10'h0c3, mux_v[5]);
        $display("triggered conversions done");
        bus(1'b1, `SADC_OFS_CTLB, 32'h0);
        n0 = nsamp;
        bus(1'b1, `SADC_OFS_CTLA, {24'h0, ctl | 8'h40});
        repeat (50 * CK) @(posedge hclk);
        chk(nsamp - n0 >= 3, 1'b1);
        chk(last_s - prev_s, 13 * CK);
        bus(1'b0, `SADC_OFS_CTLA, 32'h0);
        chk(r[6], 1'b1);
        while (sar_sample !== 1'b1)
            @(posedge hclk);
        repeat (20) @(posedge hclk);
        bus(1'b1, `SADC_OFS_CTLA, 32'h0);
        repeat (4) @(posedge hclk);
        chk(sar_phase, 1'b0);
        chk(channel_select, 4'h0);
        ctl = 8'h80 | PS;
        bus(1'b1, `SADC_OFS_CTLA, {24'h0, ctl});
        run(1'b1, 10'h377, 1'b0, 8'h00);
        res(10'h377, mux_v[5]);
        $display("free running and re-enable done");
        wrap_up();
    end
endmodule // tb
